/* File: verilog/sccr_bank.v */
// control and configuration register bank with interrupt pin shaping,
// interface options, power mode sequencing and measurement pacing.
// assumes the serial front end presents decoded byte reads and writes,
// and the fifo and measurement datapath report events as one-cycle pulses.
// clock enable low freezes every register and pulse.
`timescale 1ns/10ps
`include "sccr_regs.vh"
module sccr_bank #(
   parameter WDT_SHORT_CYC   = `SCCR_WDT_SHORT_CYC,
   parameter WDT_LONG_CYC    = `SCCR_WDT_LONG_CYC,
   parameter BASE_PERIOD_CYC = `SCCR_BASE_PERIOD_CYC
) (
   input  wire       mclk_in,
   input  wire       srst_in,
   input  wire       ce_in,
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [7:0] reg_rdata_out,
   input  wire       nvm_wdt_en_in,
   input  wire       nvm_wdt_sel_in,
   input  wire       fifo_wtm_evt_in,
   input  wire       fifo_full_evt_in,
   input  wire       drdy_evt_in,
   input  wire       meas_done_in,
   input  wire       bus_activity_in,
   output wire       irq_out,
   output wire       irq_oe_out,
   output reg        irq_aux_bit_out,
   output reg        three_wire_select_out,
   input  wire       serial_in_pin_in,
   input  wire       spi_tx_bit_in,
   input  wire       spi_tx_en_in,
   output wire       serial_in_pin_out,
   output wire       serial_in_pin_oe_out,
   output wire       serial_out_pin_out,
   output wire       serial_out_pin_oe_out,
   output wire       spi_rx_bit_out,
   output reg        wdt_timeout_out,
   output reg        press_en_out,
   output reg        temp_en_out,
   output reg  [2:0] press_oversample_out,
   output reg  [2:0] temperature_oversample_out,
   output reg  [4:0] rate_sel_out,
   output reg  [7:0] filter_coef_out,
   output reg        filter_bypass_out,
   output reg        meas_start_out,
   output reg  [1:0] power_state_out
);
   // one-hot sequencer states
   localparam ST_SLEEP  = 3'b001;
   localparam ST_FORCED = 3'b010;
   localparam ST_NORMAL = 3'b100;

   // stored configuration
   reg [7:0] int_cfg_reg;
   reg [7:0] if_cfg_reg;
   reg [7:0] power_mode_control_reg;
   reg [7:0] ovs_cfg_reg;
   reg [7:0] rate_cfg_reg;
   reg [7:0] filt_cfg_reg;

   // status flags and sequencer state
   reg [3:0] int_stat_reg;
   reg [3:0] int_stat_next;
   reg [2:0] state_reg;
   reg       forced_busy_reg;
   reg       boot_reg;

   // timer hookup and strobes
   wire      wdt_done;
   wire      tick_done;
   wire [31:0] wdt_count;
   wire [31:0] tick_count;
   wire [4:0]  rate_sat;
   wire [3:0]  evt_gated;
   wire        irq_active;
   wire        soft_reset;
   wire        wr_int, wr_if, wr_pwr, wr_ovs, wr_rate, wr_filt, rd_stat;

   // one decoder shared by every register strobe
   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // saturate the rate field to the slowest defined code
   function [4:0] rate_clip;
      input [4:0] r;
      begin
         rate_clip = (r > `SCCR_RATE_MAX) ? `SCCR_RATE_MAX : r;
      end
   endfunction

   assign wr_int  = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_INT_CFG);
   assign wr_if   = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_IF_CFG);
   assign wr_pwr  = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_POWER_MODE_CONTROL);
   assign wr_ovs  = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_OVS_CFG);
   assign wr_rate = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_RATE_CFG);
   assign wr_filt = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_FILT_CFG);
   assign rd_stat = reg_rd_in && hit(reg_addr_in, `SCCR_ADDR_INT_STATUS);

   // soft reset command
   assign soft_reset = reg_wr_in && hit(reg_addr_in, `SCCR_ADDR_CMD) &&
                       (reg_wdata_in == `SCCR_CMD_SOFTRESET); // see [RULE_18]

   // configuration storage; soft reset restores defaults
   always @(posedge mclk_in) begin
      if (srst_in) begin
         int_cfg_reg  <= `SCCR_RST_INT_CFG;
         if_cfg_reg   <= `SCCR_RST_IF_CFG;
         power_mode_control_reg <= `SCCR_RST_POWER_MODE_CONTROL;
         ovs_cfg_reg  <= `SCCR_RST_OVS_CFG;
         rate_cfg_reg <= `SCCR_RST_RATE_CFG;
         filt_cfg_reg <= `SCCR_RST_FILT_CFG;
         boot_reg     <= 1'b1;
      end else if (ce_in) begin
         boot_reg <= 1'b0;
         if (boot_reg || soft_reset) begin // see [RULE_18]
            int_cfg_reg  <= `SCCR_RST_INT_CFG;
            if_cfg_reg   <= {5'h00, nvm_wdt_sel_in, nvm_wdt_en_in,
                             1'b0}; // see [RULE_08] [RULE_09]
            power_mode_control_reg <= `SCCR_RST_POWER_MODE_CONTROL;
            ovs_cfg_reg  <= `SCCR_RST_OVS_CFG;
            rate_cfg_reg <= `SCCR_RST_RATE_CFG;
            filt_cfg_reg <= `SCCR_RST_FILT_CFG;
         end else begin
            if (wr_int)
               int_cfg_reg <= reg_wdata_in & `SCCR_MASK_INT_CFG;
            if (wr_if)
               if_cfg_reg <= reg_wdata_in & `SCCR_MASK_IF_CFG;
            // a mode write beats the forced return
            if (wr_pwr)
               power_mode_control_reg <= reg_wdata_in & `SCCR_MASK_POWER_MODE_CONTROL;
            else if (state_reg == ST_FORCED && !forced_busy_reg &&
                     !meas_start_out)
               power_mode_control_reg[5:4] <= `SCCR_MODE_SLEEP; // see [RULE_20]
            if (wr_ovs)
               ovs_cfg_reg <= reg_wdata_in & `SCCR_MASK_OVS_CFG;
            if (wr_rate)
               rate_cfg_reg <= reg_wdata_in & `SCCR_MASK_RATE_CFG;
            if (wr_filt)
               filt_cfg_reg <= reg_wdata_in & `SCCR_MASK_FILT_CFG;
         end
      end
   end

   // enabled events only; see [RULE_04] [RULE_05] [RULE_06]
   // status bit 2 has no source
   assign evt_gated = {drdy_evt_in & int_cfg_reg[`SCCR_INT_DRDY_EN_BIT],
                       1'b0,
                       fifo_full_evt_in & int_cfg_reg[`SCCR_INT_FULL_EN_BIT],
                       fifo_wtm_evt_in & int_cfg_reg[`SCCR_INT_WTM_EN_BIT]};

   // status flags: latched or following events, set wins over read clear
   always @* begin
      if (int_cfg_reg[`SCCR_INT_LATCH_BIT]) begin // see [RULE_03]
         int_stat_next = rd_stat ? 4'h0 : int_stat_reg; // see [RULE_17]
         int_stat_next = int_stat_next | evt_gated;
      end else begin
         int_stat_next = evt_gated;
      end
   end

   // flags are registered here only
   always @(posedge mclk_in) begin
      if (srst_in) begin
         int_stat_reg <= 4'h0;
      end else if (ce_in) begin
         int_stat_reg <= soft_reset ? 4'h0 : int_stat_next;
      end
   end

   // pin drive: polarity and push-pull versus open-drain
   // open-drain pulls low only, a pull-up idles it
   assign irq_active = |int_stat_reg;
   assign irq_out = irq_active ~^
                    int_cfg_reg[`SCCR_INT_LEVEL_BIT]; // see [RULE_02]
   assign irq_oe_out = int_cfg_reg[`SCCR_IRQ_DRIVE_SELECT_BIT] ?
                       (irq_out == 1'b0) : 1'b1; // see [RULE_01]

   // three-wire: data leaves on serial_in_pin, output pin floats
   assign serial_in_pin_out     = spi_tx_bit_in;
   assign serial_in_pin_oe_out  = three_wire_select_out &&
                                  spi_tx_en_in; // see [RULE_19]
   assign serial_out_pin_out    = spi_tx_bit_in;
   assign serial_out_pin_oe_out = !three_wire_select_out &&
                                  spi_tx_en_in; // see [RULE_07]
   assign spi_rx_bit_out        = serial_in_pin_in;

   // watchdog period select and restart on bus activity
   // a new period applies at the next reload
   assign wdt_count = if_cfg_reg[`SCCR_IF_WDT_SEL_BIT] ?
                      WDT_LONG_CYC - 1 : WDT_SHORT_CYC - 1; // see [RULE_09]

   sccr_timer u_wdt (
      .mclk_in  (mclk_in),
      .srst_in  (srst_in),
      .ce_in    (ce_in),
      .run_in   (if_cfg_reg[`SCCR_IF_WDT_EN_BIT]), // see [RULE_08]
      .load_in  (bus_activity_in),
      .count_in (wdt_count),
      .done_out (wdt_done)
   );

   // rate tick: base period shifted by the saturated rate code
   // big rates overflow 32 bits at full base
   assign rate_sat   = rate_clip(rate_cfg_reg[4:0]); // see [RULE_15]
   assign tick_count = (BASE_PERIOD_CYC << rate_sat) - 1; // see [RULE_14]

   sccr_timer u_tick (
      .mclk_in  (mclk_in),
      .srst_in  (srst_in),
      .ce_in    (ce_in),
      .run_in   (state_reg == ST_NORMAL),
      .load_in  (wr_rate),
      .count_in (tick_count),
      .done_out (tick_done)
   );

   // power mode sequencer
   // forced waits for done, then sleeps
   always @(posedge mclk_in) begin
      if (srst_in) begin
         state_reg       <= ST_SLEEP;
         forced_busy_reg <= 1'b0;
         meas_start_out  <= 1'b0;
      end else if (ce_in) begin
         meas_start_out <= 1'b0;
         case (state_reg)
            ST_SLEEP: begin
               if (power_mode_control_reg[5:4] == `SCCR_MODE_NORMAL) begin
                  state_reg      <= ST_NORMAL;
                  meas_start_out <= 1'b1;
               end else if (power_mode_control_reg[5:4] != `SCCR_MODE_SLEEP) begin
                  state_reg       <= ST_FORCED; // see [RULE_12]
                  forced_busy_reg <= 1'b1;
                  meas_start_out  <= 1'b1;
               end
            end
            ST_FORCED: begin
               if (meas_done_in)
                  forced_busy_reg <= 1'b0;
               if (!forced_busy_reg && !meas_start_out)
                  state_reg <= ST_SLEEP; // see [RULE_20]
            end
            ST_NORMAL: begin
               if (power_mode_control_reg[5:4] != `SCCR_MODE_NORMAL)
                  state_reg <= ST_SLEEP;
               else if (tick_done)
                  meas_start_out <= 1'b1; // see [RULE_20]
            end
            // unknown codes fall back to sleep
            default: state_reg <= ST_SLEEP;
         endcase
      end
   end

   // registered decoded settings and read data
   // copies lag the registers by one cycle
   // unmapped reads return zero
   always @(posedge mclk_in) begin
      if (srst_in) begin
         reg_rdata_out              <= 8'h00;
         irq_aux_bit_out            <= 1'b0;
         three_wire_select_out      <= 1'b0;
         wdt_timeout_out            <= 1'b0;
         press_en_out               <= 1'b0;
         temp_en_out                <= 1'b0;
         press_oversample_out       <= 3'h0;
         temperature_oversample_out <= 3'h0;
         rate_sel_out               <= 5'h00;
         filter_coef_out            <= 8'h00;
         filter_bypass_out          <= 1'b1;
         power_state_out            <= 2'h0;
      end else if (ce_in) begin
         irq_aux_bit_out       <= int_cfg_reg[5];
         three_wire_select_out <= if_cfg_reg[`SCCR_IF_3W_BIT]; // see [RULE_07]
         wdt_timeout_out       <= wdt_done; // see [RULE_08]
         press_en_out <= power_mode_control_reg[`SCCR_PWR_PRESS_BIT]; // see [RULE_10]
         temp_en_out  <= power_mode_control_reg[`SCCR_PWR_TEMP_BIT]; // see [RULE_11]
         press_oversample_out       <= ovs_cfg_reg[2:0]; // see [RULE_13]
         temperature_oversample_out <= ovs_cfg_reg[5:3]; // see [RULE_13]
         rate_sel_out               <= rate_sat;
         filter_coef_out   <= (8'h01 << filt_cfg_reg[3:1]) -
                              8'h01; // see [RULE_16]
         filter_bypass_out <= (filt_cfg_reg[3:1] == 3'h0); // see [RULE_16]
         power_state_out   <= {state_reg[2], state_reg[1]};
         if (reg_rd_in) begin
            case (reg_addr_in)
               `SCCR_ADDR_INT_STATUS: reg_rdata_out <= {4'h0, int_stat_reg};
               `SCCR_ADDR_INT_CFG:    reg_rdata_out <= int_cfg_reg;
               `SCCR_ADDR_IF_CFG:     reg_rdata_out <= if_cfg_reg;
               `SCCR_ADDR_POWER_MODE_CONTROL:   reg_rdata_out <= power_mode_control_reg;
               `SCCR_ADDR_OVS_CFG:    reg_rdata_out <= ovs_cfg_reg;
               `SCCR_ADDR_RATE_CFG:   reg_rdata_out <= rate_cfg_reg;
               `SCCR_ADDR_FILT_CFG:   reg_rdata_out <= filt_cfg_reg;
               default:               reg_rdata_out <= 8'h00;
            endcase
         end
      end
   end
endmodule

/* File: verilog/sccr_regs.vh */
// register offsets, field positions, reset values and timing counts of the
// sensor control and configuration register bank.
// assumes a byte-wide register port with 8-bit addresses and one clock.
//
// Functional notes
// [RULE_01] irq pin push-pull or open-drain by bit 0
// [RULE_02] irq pin polarity selected by bit 1
// [RULE_03] latch bit holds interrupts on pin and flags
// [RULE_04] watermark interrupt only when bit 3 set
// [RULE_05] fifo-full interrupt only when bit 4 set
// [RULE_06] data-ready interrupt only when bit 6 set
// [RULE_07] spi four-wire or three-wire by bit 0
// [RULE_08] bus watchdog runs only when enabled
// [RULE_09] watchdog timeout 1.25 ms or 40 ms
// [RULE_10] pressure measurement enabled by power bit 0
// [RULE_11] temperature measurement enabled by power bit 1
// [RULE_12] mode field: sleep, forced, or normal
// [RULE_13] oversampling codes select x1 to x32
// [RULE_14] measurement period is 5 ms times 2^rate; rates 14 to 17 wrap the 32-bit cycle count
// [RULE_15] rate codes above 17 act as 17
// [RULE_16] filter codes select bypass or coefficients
// [RULE_17] reading status clears interrupt flags
// [RULE_18] command 0xB6 restores all defaults
// [RULE_19] three-wire uses serial_in_pin both ways
// [RULE_20] forced measures once, normal repeats
`ifndef SCCR_REGS_VH
`define SCCR_REGS_VH

`define SCCR_ADDR_INT_STATUS   8'h11
`define SCCR_ADDR_INT_CFG      8'h19
`define SCCR_ADDR_IF_CFG       8'h1A
`define SCCR_ADDR_POWER_MODE_CONTROL     8'h1B
`define SCCR_ADDR_OVS_CFG      8'h1C
`define SCCR_ADDR_RATE_CFG     8'h1D
`define SCCR_ADDR_FILT_CFG     8'h1F
`define SCCR_ADDR_CMD          8'h7E

`define SCCR_CMD_SOFTRESET     8'hB6

`define SCCR_RST_INT_CFG       8'h02
`define SCCR_RST_IF_CFG        8'h00
`define SCCR_RST_POWER_MODE_CONTROL      8'h00
`define SCCR_RST_OVS_CFG       8'h02
`define SCCR_RST_RATE_CFG      8'h00
`define SCCR_RST_FILT_CFG      8'h00

`define SCCR_MASK_INT_CFG      8'h7F
`define SCCR_MASK_IF_CFG       8'h07
`define SCCR_MASK_POWER_MODE_CONTROL     8'h33
`define SCCR_MASK_OVS_CFG      8'h3F
`define SCCR_MASK_RATE_CFG     8'h1F
`define SCCR_MASK_FILT_CFG     8'h0E

`define SCCR_IRQ_DRIVE_SELECT_BIT        0
`define SCCR_INT_LEVEL_BIT     1
`define SCCR_INT_LATCH_BIT     2
`define SCCR_INT_WTM_EN_BIT    3
`define SCCR_INT_FULL_EN_BIT   4
`define SCCR_INT_DRDY_EN_BIT   6
`define SCCR_IF_3W_BIT         0
`define SCCR_IF_WDT_EN_BIT     1
`define SCCR_IF_WDT_SEL_BIT    2
`define SCCR_PWR_PRESS_BIT     0
`define SCCR_PWR_TEMP_BIT      1
`define SCCR_PWR_MODE_LSB      4
`define SCCR_STAT_WTM_BIT      0
`define SCCR_STAT_FULL_BIT     1
`define SCCR_STAT_DRDY_BIT     3

`define SCCR_MODE_SLEEP        2'h0
`define SCCR_MODE_NORMAL       2'h3
`define SCCR_RATE_MAX          5'h11

`define SCCR_CLK_MHZ           100
`define SCCR_WDT_SHORT_US      1250
`define SCCR_WDT_LONG_US       40000
`define SCCR_BASE_PERIOD_US    5000
`define SCCR_WDT_SHORT_CYC     (`SCCR_WDT_SHORT_US * `SCCR_CLK_MHZ)
`define SCCR_WDT_LONG_CYC      (`SCCR_WDT_LONG_US * `SCCR_CLK_MHZ)
`define SCCR_BASE_PERIOD_CYC   (`SCCR_BASE_PERIOD_US * `SCCR_CLK_MHZ)

`endif

/* File: verilog/sccr_timer.v */
// down-counting interval timer used for the watchdog and the rate tick.
// assumes a single clock; load restarts, done pulses one cycle at zero.
`timescale 1ns/10ps
module sccr_timer (
   input  wire        mclk_in,
   input  wire        srst_in,
   input  wire        ce_in,
   input  wire        run_in,
   input  wire        load_in,
   input  wire [31:0] count_in,
   output reg         done_out
);
   reg [31:0] cnt_reg;

   // reload on request or on expiry, else count while running
   always @(posedge mclk_in) begin
      if (srst_in) begin
         cnt_reg  <= 32'h00000000;
         done_out <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         if (load_in || !run_in) begin
            cnt_reg <= count_in;
         end else if (cnt_reg == 32'h00000000) begin
            done_out <= 1'b1;
            cnt_reg  <= count_in;
         end else begin
            cnt_reg <= cnt_reg - 32'h00000001;
         end
      end
   end
endmodule

/* File: verif/sccr_bank_props.sv */
// port checker for the sensor config register bank
// assumes the sccr_bank port names; bound to it below
`timescale 1ns/10ps
module sccr_bank_props (
   input wire       mclk_in,
   input wire       srst_in,
   input wire [7:0] reg_addr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_rdata_out,
   input wire       irq_out,
   input wire       irq_oe_out,
   input wire       three_wire_select_out,
   input wire       spi_tx_en_in,
   input wire       serial_in_pin_oe_out,
   input wire       serial_out_pin_oe_out,
   input wire       wdt_timeout_out,
   input wire [4:0] rate_sel_out,
   input wire [7:0] filter_coef_out,
   input wire       filter_bypass_out,
   input wire       meas_start_out,
   input wire [1:0] power_state_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   // pin shaping and data pin direction
   a_od_release: assert property (!irq_oe_out |-> irq_out)
      else $error("irq released while low");
   a_sdi_turn: assert property (serial_in_pin_oe_out |->
      three_wire_select_out && spi_tx_en_in)
      else $error("data pin driven outside three-wire");
   a_sdo_hiz: assert property (three_wire_select_out |->
      !serial_out_pin_oe_out) else $error("output pin driven");
   // decoded fields
   a_rate_sat: assert property (rate_sel_out <= 5'h11)
      else $error("rate above slowest");
   a_filt_code: assert property (filter_bypass_out ==
      (filter_coef_out == 8'h00) &&
      ((filter_coef_out & (filter_coef_out + 8'h01)) == 8'h00))
      else $error("bad filter coefficient");
   // read port
   a_cmd_zero: assert property (reg_rd_in &&
      reg_addr_in == 8'h7E |=> reg_rdata_out == 8'h00)
      else $error("command register not zero");
   a_rdata_hold: assert property (!reg_rd_in |=>
      $stable(reg_rdata_out)) else $error("read data moved");
   // measurement and watchdog pulses
   a_start_mode: assert property (meas_start_out |=>
      power_state_out != 2'h0) else $error("start while asleep");
   a_start_pulse: assert property (meas_start_out |=>
      !meas_start_out) else $error("start longer than a cycle");
   a_wdt_pulse: assert property (wdt_timeout_out |=>
      !wdt_timeout_out) else $error("timeout longer than a cycle");
   c_start: cover property (meas_start_out);
   c_wdt: cover property (wdt_timeout_out);
   c_irq: cover property ($rose(irq_out));
endmodule
bind sccr_bank sccr_bank_props u_props (.mclk_in(mclk_in),
   .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
   .irq_oe_out(irq_oe_out), .three_wire_select_out(three_wire_select_out),
   .spi_tx_en_in(spi_tx_en_in), .serial_in_pin_oe_out(serial_in_pin_oe_out),
   .serial_out_pin_oe_out(serial_out_pin_oe_out),
   .wdt_timeout_out(wdt_timeout_out), .rate_sel_out(rate_sel_out),
   .filter_coef_out(filter_coef_out), .filter_bypass_out(filter_bypass_out),
   .meas_start_out(meas_start_out), .power_state_out(power_state_out));

/* File: verif/sccr_host.sv */
// host controller model issuing byte register writes and reads
// assumes the bank samples strobes on the rising mclk_in edge
`timescale 1ns/10ps
module sccr_host (
   input  wire       mclk_in,
   input  wire [7:0] rdata_in,
   output reg  [7:0] addr_out,
   output reg  [7:0] wdata_out,
   output reg        wr_out,
   output reg        rd_out
);
   // idle bus at time zero
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // one write strobe; address and data scrambled once released
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(posedge mclk_in);
         addr_out <= a;
         wdata_out <= v;
         wr_out <= 1'b1;
         @(posedge mclk_in);
         wr_out <= 1'b0;
         addr_out <= ~a;
         wdata_out <= ~v;
      end
   endtask
   // one read strobe; data taken once the sampling edge has landed
   task rd(input [7:0] a, output [7:0] v);
      begin
         @(posedge mclk_in);
         addr_out <= a;
         rd_out <= 1'b1;
         @(posedge mclk_in);
         rd_out <= 1'b0;
         addr_out <= ~a;
         #1 v = rdata_in;
      end
   endtask
   // restore defaults through the command register
   task soft_reset;
      wr(8'h7E, 8'hB6);
   endtask
endmodule

/* File: verif/sccr_bank_tb.sv */
// self-checking bench for the sensor config register bank
// assumes the host model and the bound checker are compiled first
`timescale 1ns/10ps
`include "sccr_regs.vh"
module sccr_bank_tb;
   localparam [47:0] RA = {8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1F};
   localparam [47:0] RM = {8'h7F, 8'h07, 8'h33, 8'h3F, 8'h1F, 8'h0E};
   localparam [47:0] RD = {8'h02, 8'h06, 8'h00, 8'h02, 8'h00, 8'h00};
   reg        mclk_in, srst_in, act, tx_en, tx_bit, ce;
   reg  [3:0] ev;
   reg  [7:0] d;
   wire [7:0] addr, wdata, rdata, coef;
   wire       wr, rd, irq, irq_oe, tw, sdi_o, sdi_oe, sdo_o, sdo_oe, rx;
   wire       wdt, pen, ten, byp, start, aux;
   wire [2:0] posr, tosr;
   wire [4:0] rate;
   wire [1:0] pst;
   integer    n_mismatch, n_checks, i, n;
   // the data pin carries the bank's bit while it drives, else low
   wire       pin = sdi_oe ? sdi_o : 1'b0;
   sccr_host host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   sccr_bank #(.WDT_SHORT_CYC(20), .WDT_LONG_CYC(50),
      .BASE_PERIOD_CYC(10)) dut (
      .mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .nvm_wdt_en_in(1'b1),
      .nvm_wdt_sel_in(1'b1), .fifo_wtm_evt_in(ev[0]),
      .fifo_full_evt_in(ev[1]), .drdy_evt_in(ev[2]), .meas_done_in(ev[3]),
      .bus_activity_in(act), .irq_out(irq), .irq_oe_out(irq_oe),
      .irq_aux_bit_out(aux), .three_wire_select_out(tw),
      .serial_in_pin_in(pin), .spi_tx_bit_in(tx_bit), .spi_tx_en_in(tx_en),
      .serial_in_pin_out(sdi_o), .serial_in_pin_oe_out(sdi_oe),
      .serial_out_pin_out(sdo_o), .serial_out_pin_oe_out(sdo_oe),
      .spi_rx_bit_out(rx), .wdt_timeout_out(wdt), .press_en_out(pen),
      .temp_en_out(ten), .press_oversample_out(posr),
      .temperature_oversample_out(tosr), .rate_sel_out(rate),
      .filter_coef_out(coef), .filter_bypass_out(byp),
      .meas_start_out(start), .power_state_out(pst));
   // compare and count
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer k);
      begin
         repeat (k) @(posedge mclk_in);
         #1;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      begin
         host.rd(a, d);
         chk(d, e);
      end
   endtask
   // one-cycle event pulse: bits are wtm, full, drdy, done
   task pulse(input [3:0] v);
      begin
         @(posedge mclk_in);
         ev <= v;
         @(posedge mclk_in);
         ev <= 4'h0;
         #1;
      end
   endtask
   // cycles to the next start or timeout pulse, 200 when none
   task gap(input sel, output integer m);
      begin
         m = 1;
         tick(1);
         while (!(sel ? wdt : start) && m < 200) begin
            tick(1);
            m = m + 1;
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // defaults, masks, decoded copies and soft reset
   task t_regs;
      begin
         for (i = 5; i >= 0; i = i - 1)
            rdc(RA[8*i +: 8], RD[8*i +: 8]);
         rdc(`SCCR_ADDR_CMD, 8'h00);
         rdc(8'h20, 8'h00);
         for (i = 5; i >= 0; i = i - 1)
            host.wr(RA[8*i +: 8], 8'hFF);
         for (i = 5; i >= 0; i = i - 1)
            rdc(RA[8*i +: 8], RM[8*i +: 8]);
         chk({aux, pen, ten, tw, rate}, {4'hF, 5'h11});
         host.soft_reset;
         tick(2);
         for (i = 5; i >= 0; i = i - 1)
            rdc(RA[8*i +: 8], RD[8*i +: 8]);
         chk({aux, byp, pst}, 4'h4);
      end
   endtask
   // clock enable low blocks a write
   task t_ce;
      begin
         host.wr(`SCCR_ADDR_IF_CFG, 8'h00);
         repeat (2) @(posedge mclk_in);
         ce <= 1'b0;
         host.wr(`SCCR_ADDR_OVS_CFG, 8'h15);
         ce <= 1'b1;
         rdc(`SCCR_ADDR_OVS_CFG, 8'h02);
      end
   endtask
   // filter, oversampling and rate field decoding
   task t_cfg;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            host.wr(`SCCR_ADDR_FILT_CFG, {4'h0, i[2:0], 1'b0});
            host.wr(`SCCR_ADDR_OVS_CFG,
               {3'h0, i[2:1], 3'h5 - {1'b0, i[2:1]}});
            tick(2);
            chk(coef, (32'h1 << i) - 1);
            chk(byp, i == 0);
            chk({tosr, posr},
               {1'b0, i[2:1], 3'h5 - {1'b0, i[2:1]}});
         end
         for (i = 16; i < 32; i = i + 5) begin
            host.wr(`SCCR_ADDR_RATE_CFG, i[7:0]);
            tick(2);
            chk(rate, i > 17 ? 17 : i);
         end
      end
   endtask
   // interrupt gating, latching, polarity and drive type
   task t_irq;
      begin
         host.wr(`SCCR_ADDR_INT_CFG, 8'h42);
         pulse(4'h4);
         chk(irq, 1'b1);
         tick(1);
         chk(irq, 1'b0);
         host.wr(`SCCR_ADDR_INT_CFG, 8'h02);
         pulse(4'h4);
         chk(irq, 1'b0);
         host.wr(`SCCR_ADDR_INT_CFG, 8'h5E);
         pulse(4'h3);
         tick(3);
         chk(irq, 1'b1);
         rdc(`SCCR_ADDR_INT_STATUS, 8'h03);
         chk(irq, 1'b0);
         host.wr(`SCCR_ADDR_INT_CFG, 8'h16);
         pulse(4'h1);
         chk(irq, 1'b0);
         pulse(4'h2);
         rdc(`SCCR_ADDR_INT_STATUS, 8'h02);
         host.wr(`SCCR_ADDR_INT_CFG, 8'h41);
         tick(1);
         chk({irq, irq_oe}, 2'b10);
         pulse(4'h4);
         chk({irq, irq_oe}, 2'b01);
         host.wr(`SCCR_ADDR_INT_CFG, 8'h40);
         tick(1);
         chk({irq, irq_oe}, 2'b11);
      end
   endtask
   // forced modes end in sleep; normal paces starts by rate
   task t_mode;
      begin
         for (i = 1; i < 3; i = i + 1) begin
            host.wr(`SCCR_ADDR_POWER_MODE_CONTROL, {2'h0, i[1:0], 4'h3});
            tick(2);
            chk(pst, 2'h1);
            pulse(4'h8);
            tick(4);
            chk(pst, 2'h0);
            rdc(`SCCR_ADDR_POWER_MODE_CONTROL, 8'h03);
         end
         for (i = 0; i < 3; i = i + 2) begin
            host.wr(`SCCR_ADDR_RATE_CFG, i[7:0]);
            host.wr(`SCCR_ADDR_POWER_MODE_CONTROL, 8'h33);
            gap(0, n);
            gap(0, n);
            gap(0, n);
            chk(n, 10 << i);
            chk(pst, 2'h2);
         end
         host.wr(`SCCR_ADDR_POWER_MODE_CONTROL, 8'h00);
      end
   endtask
   // watchdog periods, reload by bus activity, disable
   task t_wdt;
      begin
         for (i = 0; i < 2; i = i + 1) begin
            host.wr(`SCCR_ADDR_IF_CFG, {5'h0, i[0], 2'h2});
            gap(1, n);
            gap(1, n);
            chk(n, 20 + 30 * i);
         end
         for (n = 0; n < 60; n = n + 1) begin
            @(posedge mclk_in);
            act <= (n % 8 == 0);
            #1 chk(wdt, 1'b0);
         end
         host.wr(`SCCR_ADDR_IF_CFG, 8'h00);
         gap(1, n);
         chk(n, 200);
      end
   endtask
   // data pin direction in three-wire and four-wire modes
   task t_spi;
      begin
         host.wr(`SCCR_ADDR_IF_CFG, 8'h01);
         tx_en <= 1'b1;
         tx_bit <= 1'b1;
         tick(2);
         chk({sdi_oe, sdo_oe, sdi_o, rx}, 4'hB);
         host.wr(`SCCR_ADDR_IF_CFG, 8'h00);
         tick(2);
         chk({sdi_oe, sdo_oe, sdo_o}, 3'h3);
      end
   endtask
   // free-running clock
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // hang guard
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
   end
   // reset then scenarios
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      srst_in = 1'b1;
      ev = 4'h0;
      act = 1'b0;
      tx_en = 1'b0;
      tx_bit = 1'b0;
      ce = 1'b1;
      repeat (10) @(posedge mclk_in);
      srst_in <= 1'b0;
      tick(2);
      t_regs;
      t_ce;
      t_cfg;
      t_irq;
      t_mode;
      t_wdt;
      t_spi;
      tally_and_finish;
   end
endmodule
